//--- hdl/timer16_match_capture.sv
// 16-bit timer/counter with prescaler, four matches, one capture and PWM outputs
`timescale 1ns/1ps
`default_nettype none
`include "timer16_regs.svh"

module timer16_match_capture #(
   parameter int NUM_MATCH_OUT = 3
) (
   input wire logic mclk_in,
   input wire logic reset_n_in,
   input wire logic [`T16_ADDR_W-1:0] reg_addr_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [31:0] reg_wdata_in,
   output logic [31:0] reg_rdata_out,
   input wire logic capture_in,
   output logic [NUM_MATCH_OUT-1:0] match_outputs_out
);

   if (NUM_MATCH_OUT < 1 || NUM_MATCH_OUT > `T16_NUM_MATCH) begin : g_bad_param
      $error("NUM_MATCH_OUT must lie between 1 and 4");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Functions

   function automatic logic edge_pick(input logic want_rise, input logic want_fall,
                                      input logic rise, input logic fall);
      edge_pick = (want_rise & rise) | (want_fall & fall);
   endfunction : edge_pick

   function automatic logic [31:0] widen(input logic [`T16_CNT_W-1:0] v);
      widen = {{(32-`T16_CNT_W){1'b0}}, v};
   endfunction : widen

   ////////////////////////////////////////////////////////////////////////////
   // State and helpers

   timer16_pkg::timer_state_s q;
   timer16_pkg::timer_state_s d;

   logic cap_rise;
   logic cap_fall;
   logic running;
   logic count_evt;
   logic tick;
   logic cap_evt;
   logic any_rst;
   logic any_stop;
   logic [`T16_NUM_MATCH-1:0] hit;
   logic [`T16_NUM_MATCH-1:0] hit_rst;
   logic [`T16_FLAG_W-1:0] flag_set;
   logic [`T16_FLAG_W-1:0] flag_clr;
   logic [1:0] xm_act;
   logic [31:0] rd_mux;
   timer16_pkg::count_mode_e mode;

   edge_sync u_cap_sync (
      .mclk_in(mclk_in),
      .reset_n_in(reset_n_in),
      .pin_in(capture_in),
      .rise_out(cap_rise),
      .fall_out(cap_fall)
   );

   assign mode = timer16_pkg::count_mode_e'(q.srcctl[`T16_SRC_MODE_LSB +: 2]);

   ////////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      d = q;
      running = q.control[`T16_CTL_EN] & ~q.control[`T16_CTL_RST];
      // Counter mode counts edges of the capture input instead of clocks
      unique case (mode)
         timer16_pkg::MODE_TIMER: count_evt = running;
         timer16_pkg::MODE_RISE: count_evt = running & cap_rise;
         timer16_pkg::MODE_FALL: count_evt = running & cap_fall;
         timer16_pkg::MODE_BOTH: count_evt = running & (cap_rise | cap_fall);
      endcase
      if (q.srcctl[`T16_SRC_SEL_LSB +: 2] != `T16_SRC_SEL_CAPTURE) begin
         count_evt = running & (mode == timer16_pkg::MODE_TIMER);
      end
      tick = count_evt & (q.pscount == q.plimit);

      // Matches act on the tick that would move the count off the match value
      hit = '0;
      hit_rst = '0;
      for (int n = 0; n < `T16_NUM_MATCH; n++) begin
         hit[n] = tick & (q.count == q.match[n]);
         hit_rst[n] = hit[n] & q.mctl[n*`T16_MC_STRIDE + `T16_MC_RST];
      end
      any_rst = |hit_rst;
      any_stop = 1'b0;
      flag_set = '0;
      for (int n = 0; n < `T16_NUM_MATCH; n++) begin
         any_stop = any_stop | (hit[n] & q.mctl[n*`T16_MC_STRIDE + `T16_MC_STOP]);
         flag_set[n] = hit[n] & q.mctl[n*`T16_MC_STRIDE + `T16_MC_INT];
      end
      cap_evt = edge_pick(q.capctl[`T16_CAP_RISE], q.capctl[`T16_CAP_FALL], cap_rise, cap_fall);
      flag_set[`T16_FLAG_CAP] = cap_evt & q.capctl[`T16_CAP_INT];

      // Prescaler and counter
      if (count_evt) begin
         d.pscount = tick ? '0 : q.pscount + 1'b1;
      end
      if (tick) begin
         d.count = any_rst ? '0 : q.count + 1'b1;
      end
      if (any_stop) begin
         d.control[`T16_CTL_EN] = 1'b0;
      end
      if (cap_evt) begin
         d.capture = q.count;
      end

      // External match state bits
      for (int n = 0; n < `T16_NUM_MATCH; n++) begin
         xm_act = q.xmatch[`T16_XM_CTL_LSB + n*`T16_XM_CTL_W +: `T16_XM_CTL_W];
         if (hit[n]) begin
            unique case (xm_act)
               `T16_XM_NONE: d.xmatch[n] = q.xmatch[n];
               `T16_XM_LOW: d.xmatch[n] = 1'b0;
               `T16_XM_HIGH: d.xmatch[n] = 1'b1;
               `T16_XM_TOGGLE: d.xmatch[n] = ~q.xmatch[n];
            endcase
         end
      end
      xm_act = '0;

      // Software writes: data registers take the written value over the counting update
      flag_clr = '0;
      if (reg_wr_in) begin
         unique case (reg_addr_in)
            `T16_OFS_FLAGS: flag_clr = reg_wdata_in[`T16_FLAG_W-1:0];
            `T16_OFS_CONTROL: d.control = reg_wdata_in[`T16_CTL_W-1:0];
            `T16_OFS_COUNT: d.count = reg_wdata_in[`T16_CNT_W-1:0];
            `T16_OFS_PLIMIT: d.plimit = reg_wdata_in[`T16_CNT_W-1:0];
            `T16_OFS_PSCOUNT: d.pscount = reg_wdata_in[`T16_CNT_W-1:0];
            `T16_OFS_MCTL: d.mctl = reg_wdata_in[`T16_MC_W-1:0];
            `T16_OFS_MATCH0: d.match[0] = reg_wdata_in[`T16_CNT_W-1:0];
            `T16_OFS_MATCH1: d.match[1] = reg_wdata_in[`T16_CNT_W-1:0];
            `T16_OFS_MATCH2: d.match[2] = reg_wdata_in[`T16_CNT_W-1:0];
            `T16_OFS_MATCH3: d.match[3] = reg_wdata_in[`T16_CNT_W-1:0];
            `T16_OFS_CAPCTL: d.capctl = reg_wdata_in[`T16_CAP_W-1:0];
            `T16_OFS_XMATCH: d.xmatch = reg_wdata_in[`T16_XM_W-1:0];
            `T16_OFS_SRCCTL: d.srcctl = reg_wdata_in[`T16_SRC_W-1:0];
            `T16_OFS_PWM: d.pwm = reg_wdata_in[`T16_PWM_W-1:0];
            default: d.control = d.control;
         endcase
      end
      // A flag raised in the cycle of its clear survives
      d.flags = (q.flags & ~flag_clr) | flag_set;

      // Reset bit holds both counters at zero, even against a write
      if (q.control[`T16_CTL_RST]) begin
         d.count = '0;
         d.pscount = '0;
      end

      // Outputs: PWM is low from count zero until the match value, then high
      for (int n = 0; n < `T16_NUM_MATCH; n++) begin
         d.mout[n] = q.pwm[n] ? (q.count >= q.match[n]) : q.xmatch[n];
      end

      // Read data, registered; unmapped offsets read zero
      unique case (reg_addr_in)
         `T16_OFS_FLAGS: rd_mux = {{(32-`T16_FLAG_W){1'b0}}, q.flags};
         `T16_OFS_CONTROL: rd_mux = {{(32-`T16_CTL_W){1'b0}}, q.control};
         `T16_OFS_COUNT: rd_mux = widen(q.count);
         `T16_OFS_PLIMIT: rd_mux = widen(q.plimit);
         `T16_OFS_PSCOUNT: rd_mux = widen(q.pscount);
         `T16_OFS_MCTL: rd_mux = {{(32-`T16_MC_W){1'b0}}, q.mctl};
         `T16_OFS_MATCH0: rd_mux = widen(q.match[0]);
         `T16_OFS_MATCH1: rd_mux = widen(q.match[1]);
         `T16_OFS_MATCH2: rd_mux = widen(q.match[2]);
         `T16_OFS_MATCH3: rd_mux = widen(q.match[3]);
         `T16_OFS_CAPCTL: rd_mux = {{(32-`T16_CAP_W){1'b0}}, q.capctl};
         `T16_OFS_CAPVAL: rd_mux = widen(q.capture);
         `T16_OFS_XMATCH: rd_mux = {{(32-`T16_XM_W){1'b0}}, q.xmatch};
         `T16_OFS_SRCCTL: rd_mux = {{(32-`T16_SRC_W){1'b0}}, q.srcctl};
         `T16_OFS_PWM: rd_mux = {{(32-`T16_PWM_W){1'b0}}, q.pwm};
         default: rd_mux = 32'h0000_0000;
      endcase
      if (reg_rd_in) begin
         d.rdata = rd_mux;
      end
   end

   always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign reg_rdata_out = q.rdata;
   assign match_outputs_out = q.mout[NUM_MATCH_OUT-1:0];

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!reset_n_in);

   logic wr_count;
   logic wr_ps;
   assign wr_count = reg_wr_in && reg_addr_in == `T16_OFS_COUNT;
   assign wr_ps = reg_wr_in && reg_addr_in == `T16_OFS_PSCOUNT;

   chk_count_step: assert property (
      (tick && !any_rst && !wr_count && !q.control[`T16_CTL_RST])
      |=> q.count == $past(q.count) + 16'h0001)
      else $error("count did not step on prescale tick");

   chk_ps_clear: assert property (
      (count_evt && q.pscount == q.plimit && !wr_ps && !q.control[`T16_CTL_RST])
      |=> q.pscount == 16'h0000)
      else $error("prescale count not cleared at limit");

   chk_ps_write: assert property (
      (wr_ps && !q.control[`T16_CTL_RST])
      |=> q.pscount == $past(reg_wdata_in[`T16_CNT_W-1:0]))
      else $error("prescale count write lost");

   chk_hold_reset: assert property (
      q.control[`T16_CTL_RST] |=> (q.count == 16'h0000 && q.pscount == 16'h0000))
      else $error("counter not held in reset");

   chk_match_reset: assert property (
      (any_rst && !wr_count) |=> q.count == 16'h0000)
      else $error("match reset did not clear count");

   chk_match_stop: assert property (
      (any_stop && !(reg_wr_in && reg_addr_in == `T16_OFS_CONTROL))
      |=> !q.control[`T16_CTL_EN] ##1 $stable(q.count))
      else $error("match stop did not halt counter");

   chk_capture_load: assert property (
      cap_evt |=> q.capture == $past(q.count))
      else $error("capture value not loaded");

   chk_flag_set: assert property (
      (cap_evt && q.capctl[`T16_CAP_INT]) |=> q.flags[`T16_FLAG_CAP])
      else $error("capture flag lost");

   chk_flag_clear: assert property (
      (reg_wr_in && reg_addr_in == `T16_OFS_FLAGS && reg_wdata_in[0] && !flag_set[0])
      |=> !q.flags[0])
      else $error("flag not cleared by write of one");

   chk_match_toggle: assert property (
      (hit[0] && q.xmatch[`T16_XM_CTL_LSB +: 2] == `T16_XM_TOGGLE
       && !(reg_wr_in && reg_addr_in == `T16_OFS_XMATCH))
      |=> q.xmatch[0] != $past(q.xmatch[0]))
      else $error("match toggle missing");

   chk_count_wrap: assert property (
      (tick && q.count == 16'hffff && !any_rst && !wr_count && !q.control[`T16_CTL_RST])
      |=> q.count == 16'h0000)
      else $error("count did not wrap");

   chk_flag_keep: assert property (
      (reg_wr_in && reg_addr_in == `T16_OFS_FLAGS && !reg_wdata_in[0] && q.flags[0])
      |=> q.flags[0])
      else $error("flag lost on write of zero");

   chk_pwm_level: assert property (
      q.pwm[0] |=> match_outputs_out[0] == ($past(q.count) >= $past(q.match[0])))
      else $error("pwm output level wrong");

   chk_rdata_hold: assert property (
      !reg_rd_in |=> $stable(reg_rdata_out))
      else $error("read data changed without a read");

   chk_read_pscount: assert property (
      (reg_rd_in && reg_addr_in == `T16_OFS_PSCOUNT)
      |=> reg_rdata_out == {16'h0000, $past(q.pscount)})
      else $error("prescale count read wrong");

   // Capture value is read-only: only a capture event may move it
   chk_capture_ro: assert property (
      !cap_evt |=> $stable(q.capture))
      else $error("capture value changed without capture");

   chk_match_low: assert property (
      (hit[0] && q.xmatch[`T16_XM_CTL_LSB +: `T16_XM_CTL_W] == `T16_XM_LOW
       && !(reg_wr_in && reg_addr_in == `T16_OFS_XMATCH))
      |=> !q.xmatch[0])
      else $error("match low action missing");

   chk_count_hold: assert property (
      (!q.control[`T16_CTL_EN] && !q.control[`T16_CTL_RST] && !wr_count)
      |=> $stable(q.count))
      else $error("count moved while disabled");

   chk_sel_block: assert property (
      (q.srcctl[`T16_SRC_SEL_LSB +: 2] != `T16_SRC_SEL_CAPTURE && mode != timer16_pkg::MODE_TIMER)
      |-> !count_evt)
      else $error("unselected input produced a count event");

endmodule : timer16_match_capture

`default_nettype wire

//--- pkg/timer16_regs.svh
// Register offsets, field positions and codes of the 16-bit match/capture timer
// Functional notes
// - Timer mode: count advances every limit+1 clocks
// - Prescaler clears and ticks counter after limit
// - Prescale count readable and writable by software
// - Control register enables counting and holds reset
// - Four matches select reset, stop, interrupt
// - Capture event copies count into capture value
// - Capture control picks edges and interrupt
// - Flags report five pending sources, writable clear
// - Match drives output: toggle, low, high, none
// - Match output count is an instance parameter
// - Source control picks timer or counter edges
// - Capture input may clock the counter
// - Each match output can run single-edge PWM
// - All implemented register bits reset to zero
// - Flag bits 0-3 match, bit 4 capture
// - Writing one clears flag, zero leaves it
`ifndef TIMER16_REGS_SVH
`define TIMER16_REGS_SVH

`define T16_ADDR_W 12
`define T16_CNT_W 16
`define T16_NUM_MATCH 4

`define T16_OFS_FLAGS 12'h000
`define T16_OFS_CONTROL 12'h004
`define T16_OFS_COUNT 12'h008
`define T16_OFS_PLIMIT 12'h00c
`define T16_OFS_PSCOUNT 12'h010
`define T16_OFS_MCTL 12'h014
`define T16_OFS_MATCH0 12'h018
`define T16_OFS_MATCH1 12'h01c
`define T16_OFS_MATCH2 12'h020
`define T16_OFS_MATCH3 12'h024
`define T16_OFS_CAPCTL 12'h028
`define T16_OFS_CAPVAL 12'h02c
`define T16_OFS_XMATCH 12'h03c
`define T16_OFS_SRCCTL 12'h070
`define T16_OFS_PWM 12'h074

`define T16_CTL_W 2
`define T16_CTL_EN 0
`define T16_CTL_RST 1

`define T16_MC_W 12
`define T16_MC_STRIDE 3
`define T16_MC_INT 0
`define T16_MC_RST 1
`define T16_MC_STOP 2

`define T16_CAP_W 3
`define T16_CAP_RISE 0
`define T16_CAP_FALL 1
`define T16_CAP_INT 2

`define T16_FLAG_W 5
`define T16_FLAG_CAP 4

`define T16_XM_W 12
`define T16_XM_CTL_LSB 4
`define T16_XM_CTL_W 2
`define T16_XM_NONE 2'h0
`define T16_XM_LOW 2'h1
`define T16_XM_HIGH 2'h2
`define T16_XM_TOGGLE 2'h3

`define T16_SRC_W 4
`define T16_SRC_MODE_LSB 0
`define T16_SRC_SEL_LSB 2
`define T16_SRC_SEL_CAPTURE 2'h0

`define T16_PWM_W 4

`endif

//--- pkg/timer16_pkg.sv
// Types shared by the 16-bit match/capture timer
`include "timer16_regs.svh"

package timer16_pkg;

   typedef enum logic [1:0] {
      MODE_TIMER = 2'b00,
      MODE_RISE = 2'b01,
      MODE_FALL = 2'b10,
      MODE_BOTH = 2'b11
   } count_mode_e;

   typedef struct packed {
      logic [`T16_CTL_W-1:0] control;
      logic [`T16_CNT_W-1:0] count;
      logic [`T16_CNT_W-1:0] plimit;
      logic [`T16_CNT_W-1:0] pscount;
      logic [`T16_MC_W-1:0] mctl;
      logic [`T16_NUM_MATCH-1:0][`T16_CNT_W-1:0] match;
      logic [`T16_CAP_W-1:0] capctl;
      logic [`T16_CNT_W-1:0] capture;
      logic [`T16_FLAG_W-1:0] flags;
      logic [`T16_XM_W-1:0] xmatch;
      logic [`T16_SRC_W-1:0] srcctl;
      logic [`T16_PWM_W-1:0] pwm;
      logic [`T16_NUM_MATCH-1:0] mout;
      logic [31:0] rdata;
   } timer_state_s;

   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
   } sync_state_s;

endpackage : timer16_pkg

//--- hdl/edge_sync.sv
// Two-flop synchroniser with edge detection for the capture pin
`timescale 1ns/1ps
`default_nettype none

module edge_sync (
   input wire logic mclk_in,
   input wire logic reset_n_in,
   input wire logic pin_in,
   output logic rise_out,
   output logic fall_out
);

   timer16_pkg::sync_state_s q;
   timer16_pkg::sync_state_s d;

   // First stage feeds only the second; edges look at stages two and three
   always_comb begin
      d = q;
      d.s1 = pin_in;
      d.s2 = q.s1;
      d.s3 = q.s2;
   end

   always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign rise_out = q.s2 & ~q.s3;
   assign fall_out = ~q.s2 & q.s3;

endmodule : edge_sync

`default_nettype wire

//--- bench/capture_pin_model.sv
// Pin-side model that drives the capture input of the timer
`timescale 1ns/1ps
`default_nettype none

module capture_pin_model (
   input wire logic mclk_in,
   input wire logic level_in,
   output logic pin_out
);
   logic [1:0] hold_q = 2'h0;

   initial pin_out = 1'b0;

   // A real source may not change faster than the synchroniser can see, so each level stands three clocks at least
   always @(negedge mclk_in) begin
      if (hold_q != 2'h0) begin
         hold_q <= hold_q - 2'h1;
      end else if (level_in != pin_out) begin
         pin_out <= level_in;
         hold_q <= 2'h2;
      end
   end
endmodule : capture_pin_model

`default_nettype wire

//--- bench/tb_sixteen_bit_timer_match_capture.sv
// Self-checking bench for the 16-bit match/capture timer
`timescale 1ns/1ps
`default_nettype none
`include "timer16_regs.svh"

module tb_sixteen_bit_timer_match_capture;
   logic mclk_in = 1'b0;
   logic reset_n_in = 1'b0;
   logic [11:0] addr = 12'h000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [31:0] rdata;
   logic level = 1'b0;
   logic cap_pin;
   logic [2:0] mouts;
   logic [15:0] seed = 16'h000d;
   logic [31:0] d;
   logic [15:0] v;
   logic [15:0] cap_exp;
   int failures = 0;
   int check_count = 0;
   int cycles = 0;
   int p;
   int n;
   int hi;
   logic [11:0] ofs [15] = '{12'h000, 12'h008, 12'h00c, 12'h010, 12'h014, 12'h018, 12'h01c, 12'h020,
      12'h024, 12'h028, 12'h02c, 12'h03c, 12'h070, 12'h074, 12'h004};
   logic [31:0] msk [15] = '{32'h0, 32'hffff, 32'hffff, 32'hffff, 32'hfff, 32'hffff, 32'hffff, 32'hffff,
      32'hffff, 32'h7, 32'h0, 32'hfff, 32'hf, 32'hf, 32'h2};
   logic [2:0] cap_ctl [4] = '{3'h5, 3'h2, 3'h2, 3'h1};
   logic cap_lvl [4] = '{1'b1, 1'b0, 1'b1, 1'b0};

   always #5 mclk_in = ~mclk_in;

   timer16_match_capture #(.NUM_MATCH_OUT(3)) timer16_match_capture_inst (.mclk_in(mclk_in),
      .reset_n_in(reset_n_in), .reg_addr_in(addr), .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wdata),
      .reg_rdata_out(rdata), .capture_in(cap_pin), .match_outputs_out(mouts));

   capture_pin_model capture_pin_model_inst (.mclk_in(mclk_in), .level_in(level), .pin_out(cap_pin));

   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr

   function automatic logic exp_out(input int act, input logic init);
      return (act == 0) ? init : (act == 1) ? 1'b0 : (act == 2) ? 1'b1 : ~init;
   endfunction : exp_out

   function automatic logic [31:0] exp_count(input logic [15:0] start, input int edges, input int lim);
      return {16'h0, start + 16'(edges / (lim + 1))};
   endfunction : exp_count

   function automatic logic [31:0] exp_edges(input int m);
      return (m == 4) ? 32'h0 : (m == 3) ? 32'h6 : 32'h3;
   endfunction : exp_edges

   task automatic wr_reg(input logic [11:0] a, input logic [31:0] dat);
      @(negedge mclk_in);
      addr = a;
      wdata = dat;
      wr = 1'b1;
      @(negedge mclk_in);
      wr = 1'b0;
   endtask : wr_reg

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
      check_count++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic check_reg(input string what, input logic [11:0] a, input logic [31:0] exp);
      @(negedge mclk_in);
      addr = a;
      rd = 1'b1;
      @(negedge mclk_in);
      rd = 1'b0;
      check(what, exp, rdata);
   endtask : check_reg

   task automatic restart();
      wr_reg(`T16_OFS_CONTROL, 32'h2);
      wr_reg(`T16_OFS_CONTROL, 32'h0);
   endtask : restart

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : wrap_up

   // Ceiling sits far above the fewer than one thousand cycles the sequence needs
   always @(posedge mclk_in) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         wrap_up();
      end
   end

   initial begin
      repeat (10) @(negedge mclk_in);
      reset_n_in = 1'b1;
      for (int i = 0; i < 15; i++) check_reg("reset value", ofs[i], 32'h0);
      check_reg("unmapped", 12'h040, 32'h0);
      for (int i = 0; i < 15; i++) begin
         seed = lfsr(seed);
         d = {~seed, seed};
         if (i == 14) d[0] = 1'b0;
         wr_reg(ofs[i], d);
         check_reg("register", ofs[i], d & msk[i]);
      end
      for (int i = 1; i < 15; i++) wr_reg(ofs[i], 32'h0);
      $display("test registers done");
      for (int k = 0; k < 3; k++) begin
         seed = lfsr(seed);
         p = (k == 0) ? 0 : int'(seed[2:0]);
         n = 3 * (p + 1) + int'(seed[5:3]);
         wr_reg(`T16_OFS_PLIMIT, p);
         wr_reg(`T16_OFS_COUNT, 32'hfffe);
         wr_reg(`T16_OFS_PSCOUNT, 32'h0);
         wr_reg(`T16_OFS_CONTROL, 32'h1);
         repeat (n - 2) @(negedge mclk_in);
         wr_reg(`T16_OFS_CONTROL, 32'h0);
         check_reg("count", `T16_OFS_COUNT, exp_count(16'hfffe, n, p));
         check_reg("prescale count", `T16_OFS_PSCOUNT, n % (p + 1));
      end
      $display("test prescaler done");
      wr_reg(`T16_OFS_PLIMIT, 32'h0);
      for (int a = 0; a < 4; a++) begin
         seed = lfsr(seed);
         v = {12'h0, seed[3:0]} + 16'h2;
         restart();
         wr_reg(`T16_OFS_MATCH0, v);
         wr_reg(`T16_OFS_MATCH1, v);
         wr_reg(`T16_OFS_MCTL, 32'h29);
         wr_reg(`T16_OFS_XMATCH, (a << 4) | seed[4]);
         wr_reg(`T16_OFS_FLAGS, 32'h1f);
         wr_reg(`T16_OFS_CONTROL, 32'h1);
         repeat (v + 4) @(negedge mclk_in);
         check("match output", exp_out(a, seed[4]), mouts[0]);
         check("idle match outputs", 32'h0, mouts[2:1]);
         check_reg("flags", `T16_OFS_FLAGS, 32'h3);
         check_reg("stopped control", `T16_OFS_CONTROL, 32'h0);
      end
      wr_reg(`T16_OFS_FLAGS, 32'h0);
      check_reg("flags kept", `T16_OFS_FLAGS, 32'h3);
      wr_reg(`T16_OFS_FLAGS, 32'h1);
      check_reg("flags cleared", `T16_OFS_FLAGS, 32'h2);
      $display("test match done");
      restart();
      seed = lfsr(seed);
      p = int'(seed[2:0]) + 1;
      wr_reg(`T16_OFS_XMATCH, 32'h0);
      wr_reg(`T16_OFS_MCTL, 32'h400);
      wr_reg(`T16_OFS_MATCH3, 32'h9);
      wr_reg(`T16_OFS_MATCH0, p);
      wr_reg(`T16_OFS_PWM, 32'h1);
      wr_reg(`T16_OFS_CONTROL, 32'h1);
      repeat (20) @(negedge mclk_in);
      hi = 0;
      repeat (40) begin
         @(negedge mclk_in);
         hi += int'(mouts[0]);
      end
      check("pwm high cycles", 4 * (10 - p), hi);
      wr_reg(`T16_OFS_CONTROL, 32'h0);
      wr_reg(`T16_OFS_PWM, 32'h0);
      $display("test pwm done");
      cap_exp = 16'h0;
      for (int j = 0; j < 4; j++) begin
         seed = lfsr(seed);
         wr_reg(`T16_OFS_COUNT, seed);
         wr_reg(`T16_OFS_CAPCTL, cap_ctl[j]);
         wr_reg(`T16_OFS_FLAGS, 32'h1f);
         level <= cap_lvl[j];
         repeat (6) @(negedge mclk_in);
         if (j < 2) cap_exp = seed;
         check_reg("capture value", `T16_OFS_CAPVAL, cap_exp);
         check_reg("capture flag", `T16_OFS_FLAGS, (j == 0) ? 32'h10 : 32'h0);
      end
      wr_reg(`T16_OFS_CAPCTL, 32'h0);
      $display("test capture done");
      // Pass four selects an input other than the capture pin, which must count nothing
      for (int m = 1; m < 5; m++) begin
         restart();
         wr_reg(`T16_OFS_SRCCTL, (m == 4) ? 32'h5 : m);
         wr_reg(`T16_OFS_CONTROL, 32'h1);
         repeat (3) begin
            level <= 1'b1;
            repeat (4) @(negedge mclk_in);
            level <= 1'b0;
            repeat (4) @(negedge mclk_in);
         end
         repeat (4) @(negedge mclk_in);
         wr_reg(`T16_OFS_CONTROL, 32'h0);
         check_reg("edge count", `T16_OFS_COUNT, exp_edges(m));
      end
      $display("test counter mode done");
      wrap_up();
   end
endmodule : tb_sixteen_bit_timer_match_capture

`default_nettype wire
